// ===== rtl/pin_sync3.sv
// Purpose: Three-stage synchroniser with agreement filter for asynchronous pins
// Assumes: Pins may change at any time relative to clk_sys
// Notes: Output follows once the second and third stages agree
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pins in, filtered levels out
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinLevel
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1 <= IDLE;
      stage2 <= IDLE;
      stage3 <= IDLE;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pinLevel <= IDLE;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          pinLevel[i] <= stage3[i];
        end
      end
    end
  end

endmodule

// ===== rtl/stepper_spi_pkg.sv
// Purpose: Shared constants and word layouts for the stepper driver serial interface
// Assumes: One system clock; all serial pins sampled by it
// Notes: Command and status words are 12 bits, shifted MSB first
package stepper_spi_pkg;

  localparam int WORD_BITS = 12;
  localparam int CUR_BITS = 4;
  localparam int LOAD_BITS = 3;

  // Least number of serial clocks for a transfer to count as a command
  localparam logic [3:0] MIN_CLOCKS = 4'hC;

  // Overcurrent: hits needed inside a window of PWM cycles
  localparam logic [1:0] OC_HITS = 2'h3;
  localparam logic [5:0] OC_WINDOW_LAST = 6'h3E;

  // Open load: oscillator cycles without switch-off that may pass
  localparam logic [3:0] OPEN_LOAD_LIMIT = 4'hE;

  localparam logic [CUR_BITS-1:0] CUR_OFF = 4'h0;
  localparam logic [WORD_BITS-1:0] COMMAND_RESET = 12'h000;
  localparam logic STATUS_ALWAYS_ONE = 1'b1;

  // Indexes of the three overcurrent flags
  localparam int OC_A = 0;
  localparam int OC_B = 1;
  localparam int OC_HS = 2;

  // Pin synchroniser bit order
  localparam int PIN_SCK = 0;
  localparam int PIN_SDI = 1;
  localparam int PIN_CS = 2;
  localparam int PIN_EN = 3;
  localparam int PIN_MODE = 4;
  localparam int PIN_COUNT = 5;
  // Idle levels: chip select and enable high, mode select low
  localparam logic [PIN_COUNT-1:0] PIN_IDLE = 5'h0C;

  // Command word, bit 11 down to bit 0
  typedef struct packed {
    logic mixedDecayA;
    logic [CUR_BITS-1:0] coilACurrent;
    logic polarityA;
    logic mixedDecayB;
    logic [CUR_BITS-1:0] coilBCurrent;
    logic polarityB;
  } coil_cmd_s;

  // Status word, bit 11 down to bit 0
  typedef struct packed {
    logic [LOAD_BITS-1:0] loadIndicator;
    logic alwaysOne;
    logic overtempShutdownFlag;
    logic tempPrewarningFlag;
    logic supplyLowFlag;
    logic highSideOvercurrentFlag;
    logic openLoadBFlag;
    logic openLoadAFlag;
    logic lowSideOvercurrentBFlag;
    logic lowSideOvercurrentAFlag;
  } driver_status_s;

endpackage

// ===== rtl/stepper_spi_slave.sv
// Purpose: Serial command and status interface of a two-phase stepper driver
// Assumes: Serial pins are asynchronous; chopper events are clk_sys pulses
// Notes: Sample and shift on serial clock edges found by oversampling
`timescale 1ns/1ps

// Notes on behaviour
// R01: Transfer only while chip select low
// R02: Sample input on rise, change output on fall
// R03: Both words shifted MSB first
// R04: Master gives at least twelve clocks
// R05: Extra bits reappear twelve clocks later
// R06: Chip select rise loads last twelve bits
// R07: Chip select stays low whole transfer
// R08: Bridge A fields at bits 11 to 6
// R09: Bridge B fields at bits 5 to 0
// R10: Polarity zero drives output 1 to 2
// R11: Load indicator bits 11-9, bit 8 one
// R12: Bits 7,6,5: overtemp, prewarning, undervoltage
// R13: Three overcurrents in 63 PWM cycles flag
// R14: Open load after fourteen cycles without switch-off
// R15: Open load also shown during faults
// R16: Zero current: chopper off, open load zero
// R17: Linear DAC code, zero slow decay only
// R18: Reset or enable high clears everything
// R19: Both currents zero: clear overcurrent, standby
// R20: Controller holds enable low for serial use
// R21: Output tristated unless selected and enabled
// R22: Transfers under twelve bits are ignored
// R23: Interface works only in serial mode
// R24: Enable high holds interface in reset
// R25: Status loaded into shifter on select fall
module stepper_spi_slave
  import stepper_spi_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Serial pins
  input wire logic sck,
  input wire logic sdi,
  input wire logic chipSelectLow,
  output logic sdo,
  output logic sdoOe,
  // Mode pins
  input wire logic deviceEnableLow,
  input wire logic serialModeSelect,
  // Analog and protection status
  input wire logic [LOAD_BITS-1:0] loadIndicator,
  input wire logic overtempShutdown,
  input wire logic tempPrewarning,
  input wire logic supplyLow,
  // Chopper events, one-cycle pulses
  input wire logic pwmCycleTick,
  input wire logic [2:0] overcurrentHit,
  input wire logic oscTick,
  input wire logic pwmOffA,
  input wire logic pwmOffB,
  // Bridge control
  output coil_cmd_s coilCommand,
  output logic chopperOnA,
  output logic chopperOnB,
  output logic directionRevA,
  output logic directionRevB,
  output logic lowCurrentStandby,
  output logic lowPowerStandby,
  // Status word as seen on the next transfer
  output driver_status_s statusWord
);

  logic [PIN_COUNT-1:0] pinLevel;
  logic ifaceHold;
  logic csActive;
  logic csActivePrev;
  logic sckPrev;
  logic sckRise;
  logic sckFall;
  logic csFall;
  logic csRise;
  logic [WORD_BITS-1:0] shiftReg;
  logic [3:0] bitCount;
  logic sdoBit;
  logic loadZeroBoth;
  logic [5:0] ocWindow;
  logic [1:0] ocHits [3];
  logic [2:0] ocFlag;
  logic [3:0] olCount [2];
  logic [1:0] olFlag;
  logic faultPresent;
  coil_cmd_s next_command;

  function automatic logic [3:0] sat_inc(input logic [3:0] value);
    sat_inc = (value == 4'hF) ? value : value + 4'h1;
  endfunction

  pin_sync3 #(
    .WIDTH(PIN_COUNT),
    .IDLE(PIN_IDLE)
  ) pinSync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pinIn({serialModeSelect, deviceEnableLow, chipSelectLow, sdi, sck}),
    .pinLevel(pinLevel)
  );

  // Interface held when not in serial mode or not enabled
  assign ifaceHold = !pinLevel[PIN_MODE] || pinLevel[PIN_EN]; // R23 R24
  assign csActive = !pinLevel[PIN_CS] && !ifaceHold; // R01
  assign csFall = csActive && !csActivePrev;
  assign csRise = !csActive && csActivePrev && !ifaceHold;
  assign sckRise = csActive && pinLevel[PIN_SCK] && !sckPrev;
  assign sckFall = csActive && !pinLevel[PIN_SCK] && sckPrev;
  assign next_command = coil_cmd_s'(shiftReg);

  // Edge history of the filtered pins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      csActivePrev <= 1'b0;
      sckPrev <= 1'b0;
    end else begin
      csActivePrev <= csActive;
      sckPrev <= pinLevel[PIN_SCK];
    end
  end

  // Shifter: status in at select fall, data in on rise, out on fall
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shiftReg <= '0;
      bitCount <= '0;
      sdoBit <= 1'b0;
    end else if (ifaceHold) begin
      shiftReg <= '0; // R18 R24
      bitCount <= '0;
      sdoBit <= 1'b0;
    end else if (csFall) begin
      shiftReg <= statusWord; // R25
      bitCount <= '0;
      sdoBit <= statusWord.loadIndicator[LOAD_BITS-1]; // R03
    end else if (sckRise) begin
      shiftReg <= {shiftReg[WORD_BITS-2:0], pinLevel[PIN_SDI]}; // R02 R03 R05
      bitCount <= sat_inc(bitCount);
    end else if (sckFall) begin
      sdoBit <= shiftReg[WORD_BITS-1]; // R02 R05
    end
  end

  assign sdo = sdoBit;
  assign sdoOe = csActive; // R21

  // Command register and derived bridge controls
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      coilCommand <= coil_cmd_s'(COMMAND_RESET);
      chopperOnA <= 1'b0;
      chopperOnB <= 1'b0;
      directionRevA <= 1'b0;
      directionRevB <= 1'b0;
      lowCurrentStandby <= 1'b1;
      loadZeroBoth <= 1'b0;
    end else if (ifaceHold) begin
      coilCommand <= coil_cmd_s'(COMMAND_RESET); // R18
      chopperOnA <= 1'b0;
      chopperOnB <= 1'b0;
      directionRevA <= 1'b0;
      directionRevB <= 1'b0;
      lowCurrentStandby <= 1'b1;
      loadZeroBoth <= 1'b0;
    end else if (csRise && bitCount >= MIN_CLOCKS) begin // R22
      coilCommand <= next_command; // R06 R08 R09
      // Zero code leaves the bridge in slow decay, chopper idle
      chopperOnA <= next_command.coilACurrent != CUR_OFF; // R16 R17
      chopperOnB <= next_command.coilBCurrent != CUR_OFF; // R16 R17
      directionRevA <= next_command.polarityA; // R10
      directionRevB <= next_command.polarityB; // R10
      lowCurrentStandby <= next_command.coilACurrent == CUR_OFF
        && next_command.coilBCurrent == CUR_OFF; // R19
      loadZeroBoth <= next_command.coilACurrent == CUR_OFF
        && next_command.coilBCurrent == CUR_OFF; // R19
    end else begin
      loadZeroBoth <= 1'b0;
    end
  end

  // Low power standby follows the enable pin
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lowPowerStandby <= 1'b1;
    end else begin
      lowPowerStandby <= pinLevel[PIN_EN]; // R18
    end
  end

  // Fixed window of PWM cycles for overcurrent counting
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ocWindow <= '0;
    end else if (ifaceHold) begin
      ocWindow <= '0;
    end else if (pwmCycleTick) begin
      ocWindow <= (ocWindow == OC_WINDOW_LAST) ? 6'h00 : ocWindow + 6'h01; // R13
    end
  end

  // Overcurrent hit counters and sticky flags; a new hit beats a clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        ocHits[i] <= '0;
      end
      ocFlag <= '0;
    end else if (ifaceHold) begin
      for (int i = 0; i < 3; i++) begin
        ocHits[i] <= '0;
      end
      ocFlag <= '0; // R18
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (pwmCycleTick) begin
          if (ocWindow == OC_WINDOW_LAST) begin
            ocHits[i] <= '0;
          end else if (overcurrentHit[i] && ocHits[i] != OC_HITS) begin
            ocHits[i] <= ocHits[i] + 2'h1;
          end
        end
        if (pwmCycleTick && overcurrentHit[i] && ocHits[i] == OC_HITS - 2'h1) begin
          ocFlag[i] <= 1'b1; // R13
        end else if (loadZeroBoth) begin
          ocFlag[i] <= 1'b0; // R19
        end
      end
    end
  end

  // Oscillator cycles since the last PWM switch-off, per bridge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      olCount[0] <= '0;
      olCount[1] <= '0;
    end else begin
      if (ifaceHold || !chopperOnA || pwmOffA) begin
        olCount[0] <= '0; // R16
      end else if (oscTick) begin
        olCount[0] <= sat_inc(olCount[0]); // R14
      end
      if (ifaceHold || !chopperOnB || pwmOffB) begin
        olCount[1] <= '0; // R16
      end else if (oscTick) begin
        olCount[1] <= sat_inc(olCount[1]); // R14
      end
    end
  end

  assign faultPresent = |ocFlag || supplyLow || overtempShutdown; // R15
  assign olFlag[0] = chopperOnA && (olCount[0] > OPEN_LOAD_LIMIT || faultPresent); // R14 R15 R16
  assign olFlag[1] = chopperOnB && (olCount[1] > OPEN_LOAD_LIMIT || faultPresent); // R14 R15 R16

  // Status word from live flags
  always_comb begin
    statusWord.loadIndicator = loadIndicator; // R11
    statusWord.alwaysOne = STATUS_ALWAYS_ONE; // R11
    statusWord.overtempShutdownFlag = overtempShutdown; // R12
    statusWord.tempPrewarningFlag = tempPrewarning; // R12
    statusWord.supplyLowFlag = supplyLow; // R12
    statusWord.highSideOvercurrentFlag = ocFlag[OC_HS]; // R13
    statusWord.openLoadBFlag = olFlag[1]; // R14
    statusWord.openLoadAFlag = olFlag[0]; // R14
    statusWord.lowSideOvercurrentBFlag = ocFlag[OC_B]; // R13
    statusWord.lowSideOvercurrentAFlag = ocFlag[OC_A]; // R13
  end

endmodule

// ===== test/spi_master_model.sv
// Purpose: Serial master standing in for the motion controller
// Assumes: Frames start on a clk_sys falling edge
// Notes: 80 ns serial clock; sdo read at the end of each high phase
`timescale 1ns/1ps
module spi_master_model (
  // Bus pins
  output logic sck,
  output logic sdi,
  output logic chipSelectLow,
  input wire logic sdo
);
  initial begin
    sck = 1'h0;
    sdi = 1'h0;
    chipSelectLow = 1'h1;
  end

  // Clock idles low; released data line shows the inverted last bit
  task automatic xfer(input int n, input logic [23:0] tx, output logic [23:0] rx);
    rx = '0;
    chipSelectLow = 1'h0;
    #100;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = tx[i];
      #40 sck = 1'h1;
      // Filter lag puts the new sdo bit just past the rise
      #40 rx = {rx[22:0], sdo};
      sck = 1'h0;
    end
    #60 chipSelectLow = 1'h1;
    sdi = ~sdi;
    #200;
  endtask
endmodule

// ===== test/stepper_spi_slave_bench.sv
// Purpose: Self-checking bench for the stepper serial slave
// Assumes: Inputs change on clk_sys falling edges
// Notes: Status inputs held static around each frame
`timescale 1ns/1ps
module stepper_spi_slave_bench;
  import stepper_spi_pkg::*;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic sck, sdi, chipSelectLow, sdo, sdoOe;
  logic deviceEnableLow = 1'h1;
  logic serialModeSelect = 1'h1;
  logic [2:0] loadIndicator = 3'h5;
  logic overtempShutdown = 1'h1, tempPrewarning = 1'h0, supplyLow = 1'h1;
  logic pwmCycleTick = 1'h0, oscTick = 1'h0, pwmOffA = 1'h0, pwmOffB = 1'h0;
  logic [2:0] overcurrentHit = 3'h7;
  logic chopperOnA, chopperOnB, directionRevA, directionRevB, lowCurrentStandby, lowPowerStandby;
  coil_cmd_s coilCommand;
  driver_status_s statusWord;
  logic [23:0] rx;
  int n_fail = 0, cmp_count = 0;

  always #5 clk_sys = ~clk_sys;

  stepper_spi_slave u_stepper_spi_slave (.clk_sys, .rst, .sck, .sdi, .chipSelectLow, .sdo, .sdoOe,
    .deviceEnableLow, .serialModeSelect, .loadIndicator, .overtempShutdown, .tempPrewarning, .supplyLow,
    .pwmCycleTick, .overcurrentHit, .oscTick, .pwmOffA, .pwmOffB, .coilCommand, .chopperOnA, .chopperOnB,
    .directionRevA, .directionRevB, .lowCurrentStandby, .lowPowerStandby, .statusWord);
  spi_master_model u_spi_master_model (.sck, .sdi, .chipSelectLow, .sdo);

  task automatic chk(string nm, logic [23:0] got, logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic pulse(ref logic s, input int n);
    repeat (n) begin
      @(negedge clk_sys) s = 1'h1;
      @(negedge clk_sys) s = 1'h0;
    end
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_fail++;
    test_done();
  end

  initial begin
    repeat (10) @(negedge clk_sys);
    rst = 1'h0;
    repeat (10) @(negedge clk_sys);
    chk("standby", lowPowerStandby, 1'h1);
    chk("cmd reset", coilCommand, COMMAND_RESET);
    deviceEnableLow = 1'h0;
    repeat (10) @(negedge clk_sys);
    u_spi_master_model.xfer(12, 24'h00_0000, rx);
    chk("status", rx, 24'h00_0BA0);
    loadIndicator = 3'h0;
    overtempShutdown = 1'h0;
    supplyLow = 1'h0;
    u_spi_master_model.xfer(12, 24'h00_09E3, rx);
    chk("command", coilCommand, 24'h00_09E3);
    chk("dir A", directionRevA, 1'h1);
    chk("chop B", chopperOnB, 1'h1);
    chk("dir B", directionRevB, 1'h1);
    chk("oe", sdoOe, 1'h0);
    u_spi_master_model.xfer(11, 24'h00_0000, rx);
    chk("short", coilCommand, 24'h00_09E3);
    $display("end: command");
    u_spi_master_model.xfer(24, 24'h3C_57F0, rx);
    chk("daisy", rx, 24'h10_03C5);
    chk("last 12", coilCommand, 24'h00_07F0);
    pulse(oscTick, 14);
    chk("ol 14", statusWord[3:2], 2'h0);
    pulse(oscTick, 1);
    chk("ol 15", statusWord[3:2], 2'h3);
    pulse(pwmOffA, 1);
    chk("ol off", statusWord[3:2], 2'h2);
    $display("end: open load");
    pulse(pwmCycleTick, 2);
    chk("oc 2", statusWord[4:0], 5'h08);
    pulse(pwmCycleTick, 1);
    chk("oc 3", statusWord[4:0], 5'h1F);
    u_spi_master_model.xfer(12, 24'h00_0000, rx);
    chk("oc read", rx, 24'h00_011F);
    chk("oc clr", statusWord[4:0], 5'h00);
    chk("low cur", lowCurrentStandby, 1'h1);
    $display("end: overcurrent");
    serialModeSelect = 1'h0;
    repeat (10) @(negedge clk_sys);
    u_spi_master_model.xfer(12, 24'h00_0FFF, rx);
    chk("mode off", coilCommand, 24'h00_0000);
    serialModeSelect = 1'h1;
    repeat (10) @(negedge clk_sys);
    u_spi_master_model.xfer(12, 24'h00_09E3, rx);
    chk("cmd again", coilCommand, 24'h00_09E3);
    deviceEnableLow = 1'h1;
    repeat (10) @(negedge clk_sys);
    chk("en clr", coilCommand, 24'h00_0000);
    chk("en sby", lowPowerStandby, 1'h1);
    $display("end: hold");
    test_done();
  end
endmodule

// ===== test/stepper_spi_slave_properties.sv
// Purpose: Port checks on the stepper serial slave
// Assumes: Pin filter settles within five clocks
// Notes: Repetition counts cover the pin filter lag
`timescale 1ns/1ps
module stepper_spi_slave_properties
  import stepper_spi_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pins
  input wire logic chipSelectLow,
  input wire logic deviceEnableLow,
  input wire logic serialModeSelect,
  input wire logic sdoOe,
  input wire logic [LOAD_BITS-1:0] loadIndicator,
  // Results
  input wire coil_cmd_s coilCommand,
  input wire logic chopperOnA,
  input wire logic lowCurrentStandby,
  input wire logic lowPowerStandby,
  input wire driver_status_s statusWord
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_OE_CS: assert property (chipSelectLow [*5] |-> !sdoOe)
    else $error("sdo driven while deselected");
  AST_OE_ON: assert property ((!chipSelectLow && !deviceEnableLow && serialModeSelect) [*5] |-> sdoOe)
    else $error("sdo not driven while selected");
  AST_PWR: assert property (deviceEnableLow [*6] |-> lowPowerStandby)
    else $error("no standby while disabled");
  AST_CLEAR: assert property (deviceEnableLow [*8] |-> coilCommand == COMMAND_RESET)
    else $error("command kept while disabled");
  AST_CHOP: assert property (coilCommand.coilACurrent != CUR_OFF |-> ##[0:1] chopperOnA)
    else $error("chopper A off with current set");
  AST_LOWCUR: assert property (coilCommand.coilACurrent == CUR_OFF && coilCommand.coilBCurrent == CUR_OFF
    |-> ##[0:1] lowCurrentStandby)
    else $error("no low current standby");
  AST_STATUS: assert property (statusWord.loadIndicator == loadIndicator && statusWord.alwaysOne)
    else $error("status top bits wrong");
  AST_OL_ZERO: assert property ((coilCommand.coilACurrent == CUR_OFF) [*2] |-> !statusWord.openLoadAFlag)
    else $error("open load A with zero current");
  AST_OL_FAULT: assert property (chopperOnA && statusWord.lowSideOvercurrentAFlag
    |-> statusWord.openLoadAFlag)
    else $error("open load A not shown on fault");
  AST_HOLD: assert property ((!chipSelectLow && !deviceEnableLow && serialModeSelect) [*8]
    |-> $stable(coilCommand))
    else $error("command changed in a frame");
endmodule

bind stepper_spi_slave stepper_spi_slave_properties u_props (.clk_sys, .rst, .chipSelectLow, .deviceEnableLow,
  .serialModeSelect, .sdoOe, .loadIndicator, .coilCommand, .chopperOnA, .lowCurrentStandby, .lowPowerStandby,
  .statusWord);
